// >>> fspc_cfg.svh
`ifndef FSPC_CFG_SVH
`define FSPC_CFG_SVH

// control and status register placement
`define FSPC_CSR_IO_ADDR 6'h37
`define FSPC_CSR_MEM_ADDR 8'h57
`define FSPC_CSR_RESET 8'h00

// control and status register bit positions
`define FSPC_BIT_IE 7
`define FSPC_BIT_BUSY 6
`define FSPC_BIT_REEN 4
`define FSPC_BIT_LOCK 3
`define FSPC_BIT_WRITE 2
`define FSPC_BIT_ERASE 1
`define FSPC_BIT_EN 0

// accepted patterns of the lower five bits
`define FSPC_PAT_REEN 5'h11
`define FSPC_PAT_LOCK 5'h09
`define FSPC_PAT_WRITE 5'h05
`define FSPC_PAT_ERASE 5'h03
`define FSPC_PAT_FILL 5'h01

// arming windows in core clock cycles
`define FSPC_STORE_WINDOW 3'h4
`define FSPC_LOAD_WINDOW 3'h3

// programming time, shortest figure, rounded up to whole cycles
`define FSPC_CLK_PERIOD_NS 40
`define FSPC_PROG_MIN_NS 3700000
`define FSPC_PROG_MAX_NS 4500000
`define FSPC_PROG_CYCLES ((`FSPC_PROG_MIN_NS + `FSPC_CLK_PERIOD_NS - 1) / `FSPC_CLK_PERIOD_NS)

// memory geometry
`define FSPC_PAGE_WORDS 64
`define FSPC_RWW_LAST_PAGE 7'h6F
`define FSPC_BOOT_START_128 13'h1F80
`define FSPC_BOOT_START_256 13'h1F00
`define FSPC_BOOT_START_512 13'h1E00
`define FSPC_BOOT_START_1024 13'h1C00

// lock bits, unprogrammed reads as one
`define FSPC_LOCK_RESET 6'h3F
`define FSPC_LOCK_PAD 2'h3

`endif

// >>> fspc_pkg.sv
package fspc_pkg;

	typedef enum logic [2:0] {
		FSPC_CMD_NONE = 3'h0,
		FSPC_CMD_FILL = 3'h1,
		FSPC_CMD_ERASE = 3'h2,
		FSPC_CMD_WRITE = 3'h3,
		FSPC_CMD_LOCK = 3'h4,
		FSPC_CMD_REEN = 3'h5
	} fspc_cmd_e;

	typedef enum logic [1:0] {
		FSPC_ST_IDLE = 2'h0,
		FSPC_ST_ARMED = 2'h1,
		FSPC_ST_BUSY = 2'h3
	} fspc_state_e;

endpackage : fspc_pkg

// >>> fspc_core_if.sv
`timescale 1ns/1ps
interface fspc_core_if;
	logic tmr_start;
	logic tmr_done;
	logic buf_fill;
	logic [5:0] buf_idx;
	logic [15:0] buf_wdata;
	logic buf_abort;
	logic buf_clear;
	logic buf_loading;
	logic [5:0] rd_idx;
	logic [15:0] rd_data;

	modport ctrl (output tmr_start, input tmr_done, output buf_fill, output buf_idx, output buf_wdata,
		output buf_abort, output buf_clear, input buf_loading, output rd_idx, input rd_data);
	modport buff (input buf_fill, input buf_idx, input buf_wdata, input buf_abort, input buf_clear,
		output buf_loading, input rd_idx, output rd_data);
	modport tmr (input tmr_start, output tmr_done);
endinterface : fspc_core_if

// >>> fspc_op_timer.sv
`timescale 1ns/1ps
module fspc_op_timer #(
	parameter int unsigned CYCLES = 92500
) (
	input wire logic clk,
	input wire logic reset,
	fspc_core_if.tmr core
);
	generate
		if (CYCLES < 2) begin : g_bad
			$error("fspc_op_timer: CYCLES must be at least 2");
		end
	endgenerate

	logic [31:0] cnt_r;
	logic run_r;
	logic done_r;

	always_ff @(posedge clk) begin
		if (reset) begin
			cnt_r <= 32'h0;
			run_r <= 1'b0;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (core.tmr_start) begin
				cnt_r <= 32'(CYCLES - 1);
				run_r <= 1'b1;
			end else if (run_r) begin
				if (cnt_r == 32'h1) begin
					run_r <= 1'b0;
					done_r <= 1'b1;
				end
				cnt_r <= cnt_r - 32'h1;
			end
		end
	end

	assign core.tmr_done = done_r;
endmodule : fspc_op_timer

// >>> fspc_page_buffer.sv
`timescale 1ns/1ps
module fspc_page_buffer #(
	parameter int unsigned WORDS = 64
) (
	input wire logic clk,
	input wire logic reset,
	fspc_core_if.buff core
);
	generate
		if (WORDS != 64) begin : g_bad
			$error("fspc_page_buffer: six-bit word index serves exactly 64 words");
		end
	endgenerate

	logic [15:0] mem [WORDS];
	logic [WORDS-1:0] valid_r;
	logic [15:0] rd_data_r;

	always_ff @(posedge clk) begin
		if (core.buf_fill) begin
			mem[core.buf_idx] <= core.buf_wdata;
		end
	end

	// words never loaded read as erased so a dropped load cannot leak stale data
	always_ff @(posedge clk) begin
		if (reset || core.buf_abort || core.buf_clear) begin
			valid_r <= '0;
		end else if (core.buf_fill) begin
			valid_r[core.buf_idx] <= 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rd_data_r <= 16'hFFFF;
		end else begin
			rd_data_r <= valid_r[core.rd_idx] ? mem[core.rd_idx] : 16'hFFFF;
		end
	end

	assign core.rd_data = rd_data_r;
	assign core.buf_loading = |valid_r;
endmodule : fspc_page_buffer

// >>> fspc_ctrl.sv
`timescale 1ns/1ps
`include "fspc_cfg.svh"
module fspc_ctrl #(
	parameter int unsigned PROG_CYCLES = `FSPC_PROG_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [5:0] io_addr,
	input wire logic io_wr,
	input wire logic [7:0] io_wdata,
	output logic [7:0] io_rdata,
	input wire logic store_exec,
	input wire logic load_exec,
	input wire logic [15:0] z_ptr,
	input wire logic [7:0] data_low_register,
	input wire logic [7:0] data_high_register,
	input wire logic global_int_enable,
	input wire logic eeprom_write_busy_bit,
	input wire logic [1:0] boot_size_fuses,
	input wire logic [7:0] fuse_low_byte,
	input wire logic [7:0] fuse_high_byte,
	input wire logic [7:0] fuse_ext_byte,
	output logic load_special_valid,
	output logic [7:0] load_special_data,
	output logic cpu_stall,
	output logic rww_read_blocked,
	output logic ready_irq,
	output logic [12:0] boot_start_word,
	output logic [5:0] lock_bits,
	output logic flash_erase_start,
	output logic flash_write_start,
	output logic flash_busy,
	output logic [6:0] flash_page,
	input wire logic [5:0] flash_rd_idx,
	output logic [15:0] flash_rd_data
);
	generate
		if (PROG_CYCLES < 2) begin : g_bad
			$error("fspc_ctrl: PROG_CYCLES must be at least 2");
		end
	endgenerate

	function automatic fspc_pkg::fspc_cmd_e cmd_decode(input logic [4:0] bits);
		case (bits)
			`FSPC_PAT_FILL: cmd_decode = fspc_pkg::FSPC_CMD_FILL;
			`FSPC_PAT_ERASE: cmd_decode = fspc_pkg::FSPC_CMD_ERASE;
			`FSPC_PAT_WRITE: cmd_decode = fspc_pkg::FSPC_CMD_WRITE;
			`FSPC_PAT_LOCK: cmd_decode = fspc_pkg::FSPC_CMD_LOCK;
			`FSPC_PAT_REEN: cmd_decode = fspc_pkg::FSPC_CMD_REEN;
			default: cmd_decode = fspc_pkg::FSPC_CMD_NONE;
		endcase
	endfunction : cmd_decode

	// command bits without store-enable, which follows the state
	function automatic logic [4:1] cmd_bits(input fspc_pkg::fspc_cmd_e cmd);
		case (cmd)
			fspc_pkg::FSPC_CMD_ERASE: cmd_bits = 4'h1;
			fspc_pkg::FSPC_CMD_WRITE: cmd_bits = 4'h2;
			fspc_pkg::FSPC_CMD_LOCK: cmd_bits = 4'h4;
			fspc_pkg::FSPC_CMD_REEN: cmd_bits = 4'h8;
			default: cmd_bits = 4'h0;
		endcase
	endfunction : cmd_bits

	function automatic logic [12:0] boot_start(input logic [1:0] fuses);
		case (fuses)
			2'h3: boot_start = `FSPC_BOOT_START_128;
			2'h2: boot_start = `FSPC_BOOT_START_256;
			2'h1: boot_start = `FSPC_BOOT_START_512;
			default: boot_start = `FSPC_BOOT_START_1024;
		endcase
	endfunction : boot_start

	fspc_core_if core ();

	fspc_op_timer #(
		.CYCLES(PROG_CYCLES)
	) u_timer (
		.clk(clk),
		.reset(reset),
		.core(core.tmr)
	);

	fspc_page_buffer #(
		.WORDS(`FSPC_PAGE_WORDS)
	) u_buffer (
		.clk(clk),
		.reset(reset),
		.core(core.buff)
	);

	fspc_pkg::fspc_state_e state_r;
	fspc_pkg::fspc_cmd_e cmd_r;
	fspc_pkg::fspc_cmd_e wr_cmd;
	logic [2:0] win_r;
	logic ie_r;
	logic busy_flag_r;
	logic no_read_while_write_area_r;
	logic [6:0] page_r;
	logic [5:0] lock_data_r;
	logic [5:0] lock_bits_r;
	logic [7:0] io_rdata_r;
	logic load_valid_r;
	logic [7:0] load_data_r;
	logic erase_start_r;
	logic write_start_r;
	logic [12:0] boot_start_r;
	logic wr_hit;
	logic accept;
	logic store_fire;
	logic load_fire;
	logic flash_op;
	logic timed_op;
	logic [6:0] z_page;
	logic [5:0] z_word;
	logic [7:0] csr_view;

	assign wr_hit = io_wr && (io_addr == `FSPC_CSR_IO_ADDR);
	assign wr_cmd = cmd_decode(io_wdata[4:0]);
	// no command is taken while flash is busy or an eeprom write runs
	assign accept = wr_hit && (wr_cmd != fspc_pkg::FSPC_CMD_NONE)
		&& (state_r != fspc_pkg::FSPC_ST_BUSY) && !eeprom_write_busy_bit;
	assign store_fire = store_exec && (state_r == fspc_pkg::FSPC_ST_ARMED) && (win_r != 3'h0);
	// lock or fuse read counts only in the first three armed cycles
	assign load_fire = load_exec && (state_r == fspc_pkg::FSPC_ST_ARMED) && (cmd_r == fspc_pkg::FSPC_CMD_LOCK)
		&& (win_r > (`FSPC_STORE_WINDOW - `FSPC_LOAD_WINDOW)) && !eeprom_write_busy_bit;
	assign flash_op = (cmd_r == fspc_pkg::FSPC_CMD_ERASE) || (cmd_r == fspc_pkg::FSPC_CMD_WRITE);
	assign timed_op = flash_op || (cmd_r == fspc_pkg::FSPC_CMD_LOCK);
	// top two pointer bits never reach the decode
	assign z_page = z_ptr[13:7];
	assign z_word = z_ptr[6:1];

	// arming state; store-enable reads set in every state but idle
	always_ff @(posedge clk) begin
		if (reset) begin
			state_r <= fspc_pkg::FSPC_ST_IDLE;
		end else begin
			case (state_r)
				fspc_pkg::FSPC_ST_IDLE: begin
					if (accept) begin
						state_r <= fspc_pkg::FSPC_ST_ARMED;
					end
				end
				fspc_pkg::FSPC_ST_ARMED: begin
					if (store_fire) begin
						state_r <= timed_op ? fspc_pkg::FSPC_ST_BUSY : fspc_pkg::FSPC_ST_IDLE;
					end else if (load_fire) begin
						state_r <= fspc_pkg::FSPC_ST_IDLE;
					end else if (accept) begin
						state_r <= fspc_pkg::FSPC_ST_ARMED;
					end else if (win_r <= 3'h1) begin
						state_r <= fspc_pkg::FSPC_ST_IDLE;
					end
				end
				fspc_pkg::FSPC_ST_BUSY: begin
					if (core.tmr_done) begin
						state_r <= fspc_pkg::FSPC_ST_IDLE;
					end
				end
				default: state_r <= fspc_pkg::FSPC_ST_IDLE;
			endcase
		end
	end

	// window counter, reloaded by an accepted command write unless a store or load fires in the same cycle
	always_ff @(posedge clk) begin
		if (reset) begin
			win_r <= 3'h0;
		end else if (accept && !store_fire && !load_fire) begin
			win_r <= `FSPC_STORE_WINDOW;
		end else if (store_fire || load_fire) begin
			win_r <= 3'h0;
		end else if (win_r != 3'h0) begin
			win_r <= win_r - 3'h1;
		end
	end

	// command bits follow the arming and clear with store-enable
	always_ff @(posedge clk) begin
		if (reset) begin
			cmd_r <= fspc_pkg::FSPC_CMD_NONE;
		end else begin
			case (state_r)
				fspc_pkg::FSPC_ST_IDLE: begin
					cmd_r <= accept ? wr_cmd : fspc_pkg::FSPC_CMD_NONE;
				end
				fspc_pkg::FSPC_ST_ARMED: begin
					if (store_fire) begin
						cmd_r <= timed_op ? cmd_r : fspc_pkg::FSPC_CMD_NONE;
					end else if (load_fire) begin
						cmd_r <= fspc_pkg::FSPC_CMD_NONE;
					end else if (accept) begin
						cmd_r <= wr_cmd;
					end else if (win_r <= 3'h1) begin
						cmd_r <= fspc_pkg::FSPC_CMD_NONE;
					end
				end
				fspc_pkg::FSPC_ST_BUSY: begin
					if (core.tmr_done) begin
						cmd_r <= fspc_pkg::FSPC_CMD_NONE;
					end
				end
				default: cmd_r <= fspc_pkg::FSPC_CMD_NONE;
			endcase
		end
	end

	// interrupt enable is writable regardless of the lower bits
	always_ff @(posedge clk) begin
		if (reset) begin
			ie_r <= 1'b0;
		end else if (wr_hit) begin
			ie_r <= io_wdata[`FSPC_BIT_IE];
		end
	end

	// read-while-write busy flag, hardware owned
	always_ff @(posedge clk) begin
		if (reset) begin
			busy_flag_r <= 1'b0;
		end else if (store_fire && flash_op && (z_page <= `FSPC_RWW_LAST_PAGE)) begin
			busy_flag_r <= 1'b1;
		end else if (store_fire && ((cmd_r == fspc_pkg::FSPC_CMD_REEN) || (cmd_r == fspc_pkg::FSPC_CMD_FILL))) begin
			busy_flag_r <= 1'b0;
		end
	end

	// operation target latched at the store so the pointer may move meanwhile
	always_ff @(posedge clk) begin
		if (reset) begin
			page_r <= 7'h0;
			no_read_while_write_area_r <= 1'b0;
			lock_data_r <= `FSPC_LOCK_RESET;
		end else if (store_fire) begin
			page_r <= z_page;
			no_read_while_write_area_r <= flash_op && (z_page > `FSPC_RWW_LAST_PAGE);
			lock_data_r <= data_low_register[5:0];
		end
	end

	// lock bits only move toward programmed; only reset reloads them unprogrammed
	always_ff @(posedge clk) begin
		if (reset) begin
			lock_bits_r <= `FSPC_LOCK_RESET;
		end else if (core.tmr_done && (state_r == fspc_pkg::FSPC_ST_BUSY) && (cmd_r == fspc_pkg::FSPC_CMD_LOCK)) begin
			lock_bits_r <= lock_bits_r & lock_data_r;
		end
	end

	// special load answer; pointer bits 1:0 choose the byte
	always_ff @(posedge clk) begin
		if (reset) begin
			load_valid_r <= 1'b0;
			load_data_r <= 8'h00;
		end else begin
			load_valid_r <= load_fire;
			if (load_fire) begin
				case (z_ptr[1:0])
					2'h0: load_data_r <= fuse_low_byte;
					2'h1: load_data_r <= {`FSPC_LOCK_PAD, lock_bits_r};
					2'h2: load_data_r <= fuse_ext_byte;
					default: load_data_r <= fuse_high_byte;
				endcase
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			erase_start_r <= 1'b0;
			write_start_r <= 1'b0;
		end else begin
			erase_start_r <= store_fire && (cmd_r == fspc_pkg::FSPC_CMD_ERASE);
			write_start_r <= store_fire && (cmd_r == fspc_pkg::FSPC_CMD_WRITE);
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			boot_start_r <= `FSPC_BOOT_START_1024;
		end else begin
			boot_start_r <= boot_start(boot_size_fuses);
		end
	end

	// reserved bit 5 always zero
	assign csr_view = {ie_r, busy_flag_r, 1'b0, cmd_bits(cmd_r), state_r != fspc_pkg::FSPC_ST_IDLE};

	always_ff @(posedge clk) begin
		if (reset) begin
			io_rdata_r <= `FSPC_CSR_RESET;
		end else begin
			io_rdata_r <= csr_view;
		end
	end

	// buffer fill ignores the data pair for every other command
	assign core.buf_fill = store_fire && (cmd_r == fspc_pkg::FSPC_CMD_FILL);
	assign core.buf_idx = z_word;
	assign core.buf_wdata = {data_high_register, data_low_register};
	assign core.buf_abort = wr_hit && io_wdata[`FSPC_BIT_REEN] && core.buf_loading;
	assign core.buf_clear = core.tmr_done && (state_r == fspc_pkg::FSPC_ST_BUSY) && (cmd_r == fspc_pkg::FSPC_CMD_WRITE);
	assign core.rd_idx = flash_rd_idx;
	// one timer serves erase, write and lock; shortest time keeps the core moving soonest
	assign core.tmr_start = store_fire && timed_op;

	assign io_rdata = io_rdata_r;
	assign load_special_valid = load_valid_r;
	assign load_special_data = load_data_r;
	assign cpu_stall = (state_r == fspc_pkg::FSPC_ST_BUSY) && no_read_while_write_area_r;
	assign rww_read_blocked = busy_flag_r;
	assign ready_irq = ie_r && global_int_enable && (state_r == fspc_pkg::FSPC_ST_IDLE);
	assign boot_start_word = boot_start_r;
	assign lock_bits = lock_bits_r;
	assign flash_erase_start = erase_start_r;
	assign flash_write_start = write_start_r;
	assign flash_busy = (state_r == fspc_pkg::FSPC_ST_BUSY) && flash_op;
	assign flash_page = page_r;
	assign flash_rd_data = core.rd_data;
endmodule : fspc_ctrl

// >>> fspc_cpu_model.sv
`timescale 1ns/1ps
// core side: timed register write, then store or load
module fspc_cpu_model (
	input wire logic clk,
	output logic [5:0] io_addr = 6'h37,
	output logic io_wr = 1'b0,
	output logic [7:0] io_wdata = 8'h00,
	output logic store_exec = 1'b0,
	output logic load_exec = 1'b0
);
	// gap is the edge after the write that takes the instruction; 0 skips it
	task op(input logic [7:0] v, input int gap, input logic ldp);
		@(posedge clk);
		io_wr <= 1'b1;
		io_wdata <= v;
		@(posedge clk);
		io_wr <= 1'b0;
		io_wdata <= ~v;
		if (gap > 0) begin
			repeat (gap - 1) @(posedge clk);
			if (ldp) load_exec <= 1'b1;
			else store_exec <= 1'b1;
			@(posedge clk);
			load_exec <= 1'b0;
			store_exec <= 1'b0;
		end
		#1;
	endtask : op
endmodule : fspc_cpu_model

// >>> fspc_ctrl_checker.sv
`timescale 1ns/1ps
`include "fspc_cfg.svh"
module fspc_ctrl_checker #(
	parameter int unsigned PROG_CYCLES = `FSPC_PROG_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic store_exec,
	input wire logic load_exec,
	input wire logic global_int_enable,
	input wire logic load_special_valid,
	input wire logic cpu_stall,
	input wire logic rww_read_blocked,
	input wire logic ready_irq,
	input wire logic flash_erase_start,
	input wire logic flash_write_start,
	input wire logic flash_busy,
	input wire logic [6:0] flash_page
);
	default clocking dck @(posedge clk);
	endclocking
	default disable iff (reset);
	logic [31:0] busy_cnt;
	// busy length is counted so the check needs no long repetition
	always_ff @(posedge clk) begin
		if (reset || !flash_busy) begin
			busy_cnt <= 32'h0;
		end else begin
			busy_cnt <= busy_cnt + 32'h1;
		end
	end
	sequence busy_end;
		$fell(flash_busy);
	endsequence
	sequence busy_len_ok;
		busy_cnt == PROG_CYCLES;
	endsequence
	AST_BUSY_TIME: assert property (busy_end |-> busy_len_ok)
		else $error("busy length wrong");
	AST_START_BUSY: assert property (flash_erase_start || flash_write_start |-> flash_busy)
		else $error("start without busy");
	AST_WRITE_PULSE: assert property (flash_write_start |=> !flash_write_start)
		else $error("write start too long");
	AST_ONE_OP: assert property (!(flash_erase_start && flash_write_start))
		else $error("erase and write together");
	AST_STALL_NO_READ_WHILE_WRITE_AREA: assert property (cpu_stall |-> flash_busy && flash_page >= 7'h70)
		else $error("stall outside no_read_while_write_area op");
	AST_STALL_HELD: assert property (flash_busy && flash_page >= 7'h70 |-> cpu_stall)
		else $error("no_read_while_write_area op without stall");
	AST_RWW_SET: assert property ((flash_erase_start || flash_write_start) && flash_page < 7'h70
		|-> rww_read_blocked)
		else $error("busy flag not set");
	AST_RWW_HELD: assert property (flash_busy && flash_page < 7'h70 |-> rww_read_blocked)
		else $error("busy flag dropped in op");
	AST_RWW_CLEAR: assert property ($fell(rww_read_blocked)
		|-> $past(store_exec) || $past(store_exec, 2) || $past(store_exec, 3))
		else $error("busy flag cleared without store");
	AST_IRQ: assert property (ready_irq |-> global_int_enable && !flash_busy)
		else $error("irq without cause");
	AST_LOAD: assert property (load_special_valid |-> $past(load_exec))
		else $error("special load without load");
endmodule : fspc_ctrl_checker

// >>> tb_fspc_ctrl.sv
`timescale 1ns/1ps
module tb_fspc_ctrl;
	localparam logic [7:0] FL = 8'h5A;
	localparam logic [7:0] FH = 8'hC3;
	localparam logic [7:0] FE = 8'hF9;
	logic clk, reset, gie, ee, io_wr, st, ld, lsv, stall, blk, irq, ers, wrs, busy;
	logic [1:0] bsz;
	logic [5:0] io_addr, ridx, lockb;
	logic [6:0] page;
	logic [7:0] io_wdata, dlo, dhi, rdat, lsd;
	logic [12:0] boot;
	logic [15:0] z, rdd;
	int num_errors = 0;
	int n_tests = 0;
	int n_er = 0;
	int n_wr = 0;
	int n_ld = 0;
	int n_st = 0;
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	fspc_cpu_model u_fspc_cpu_model (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_wdata(io_wdata),
		.store_exec(st), .load_exec(ld));
	fspc_ctrl #(.PROG_CYCLES(8)) u_fspc_ctrl (.clk(clk), .reset(reset), .io_addr(io_addr), .io_wr(io_wr),
		.io_wdata(io_wdata), .io_rdata(rdat), .store_exec(st), .load_exec(ld), .z_ptr(z),
		.data_low_register(dlo), .data_high_register(dhi), .global_int_enable(gie),
		.eeprom_write_busy_bit(ee), .boot_size_fuses(bsz), .fuse_low_byte(FL), .fuse_high_byte(FH),
		.fuse_ext_byte(FE), .load_special_valid(lsv), .load_special_data(lsd), .cpu_stall(stall),
		.rww_read_blocked(blk), .ready_irq(irq), .boot_start_word(boot), .lock_bits(lockb),
		.flash_erase_start(ers), .flash_write_start(wrs), .flash_busy(busy), .flash_page(page),
		.flash_rd_idx(ridx), .flash_rd_data(rdd));
	// pulses counted on the falling edge, clear of register updates
	always @(negedge clk) begin
		n_er <= n_er + int'(ers === 1'b1);
		n_wr <= n_wr + int'(wrs === 1'b1);
		n_ld <= n_ld + int'(lsv === 1'b1);
		n_st <= n_st + int'(stall === 1'b1);
	end
	task look(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : look
	task chk(input logic [15:0] got, input logic [15:0] exp);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task wait_idle;
		int k;
		k = 0;
		look(3);
		while (rdat[0] !== 1'b0 && k < 40) begin
			look(1);
			k++;
		end
		chk({15'h0, k < 40}, 16'h0001);
	endtask : wait_idle
	task t_boot;
		logic [12:0] ex [4];
		ex = '{13'h1C00, 13'h1E00, 13'h1F00, 13'h1F80};
		chk(rdat, 16'h0000);
		chk(lockb, 16'h003F);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			bsz <= 2'(i);
			look(3);
			chk(boot, ex[i]);
		end
		$display("t_boot done");
	endtask : t_boot
	task t_fill;
		@(posedge clk);
		z <= 16'hC00B;
		dlo <= 8'h5A;
		dhi <= 8'hA5;
		ridx <= 6'h05;
		u_fspc_cpu_model.op(8'h01, 1, 1'b0);
		look(3);
		chk(rdd, 16'hA55A);
		u_fspc_cpu_model.op(8'h11, 0, 1'b0);
		look(3);
		chk(rdd, 16'hFFFF);
		u_fspc_cpu_model.op(8'h01, 0, 1'b0);
		u_fspc_cpu_model.op(8'h01, 4, 1'b0);
		look(3);
		chk(rdd, 16'hA55A);
		$display("t_fill done");
	endtask : t_fill
	task t_refuse;
		logic [7:0] v [4];
		int g [4];
		v = '{8'h03, 8'h07, 8'h20, 8'h1F};
		g = '{5, 1, 0, 1};
		for (int i = 0; i < 4; i++) begin
			u_fspc_cpu_model.op(v[i], g[i], 1'b0);
			look(4);
			chk(rdat, 16'h0000);
			chk(n_er + n_wr, 16'h0000);
		end
		@(posedge clk);
		u_fspc_cpu_model.io_addr <= 6'h36;
		u_fspc_cpu_model.op(8'h83, 1, 1'b0);
		look(4);
		chk(rdat, 16'h0000);
		chk(n_er, 16'h0000);
		@(posedge clk);
		u_fspc_cpu_model.io_addr <= 6'h37;
		$display("t_refuse done");
	endtask : t_refuse
	task t_erase;
		@(posedge clk);
		z <= 16'h0180;
		u_fspc_cpu_model.op(8'h03, 4, 1'b0);
		look(3);
		chk(rdat[0], 16'h0001);
		chk(busy, 16'h0001);
		chk(page, 16'h0003);
		chk(blk, 16'h0001);
		u_fspc_cpu_model.op(8'h11, 1, 1'b0);
		wait_idle();
		chk(n_er, 16'h0001);
		chk(blk, 16'h0001);
		u_fspc_cpu_model.op(8'h11, 1, 1'b0);
		look(3);
		chk(blk, 16'h0000);
		@(posedge clk);
		z <= 16'h3800;
		u_fspc_cpu_model.op(8'h05, 1, 1'b0);
		wait_idle();
		chk(n_wr, 16'h0001);
		chk(n_st > 0, 16'h0001);
		chk(blk, 16'h0000);
		chk(page, 16'h0070);
		$display("t_erase done");
	endtask : t_erase
	task t_lock;
		logic [7:0] ex [4];
		int n0;
		ex = '{FL, 8'hF2, FE, FH};
		@(posedge clk);
		dlo <= 8'hF2;
		u_fspc_cpu_model.op(8'h09, 1, 1'b0);
		wait_idle();
		chk(lockb, 16'h0032);
		for (int i = 0; i < 4; i++) begin
			@(posedge clk);
			z <= 16'(i);
			u_fspc_cpu_model.op(8'h09, 3, 1'b1);
			look(2);
			chk(lsd, ex[i]);
		end
		n0 = n_ld + n_er;
		@(posedge clk);
		ee <= 1'b1;
		u_fspc_cpu_model.op(8'h09, 3, 1'b1);
		u_fspc_cpu_model.op(8'h03, 1, 1'b0);
		look(3);
		chk(n_ld + n_er, 16'(n0));
		@(posedge clk);
		ee <= 1'b0;
		$display("t_lock done");
	endtask : t_lock
	task t_irq;
		@(posedge clk);
		gie <= 1'b1;
		u_fspc_cpu_model.op(8'h80, 0, 1'b0);
		look(3);
		chk(irq, 16'h0001);
		u_fspc_cpu_model.op(8'h83, 1, 1'b0);
		look(2);
		chk(irq, 16'h0000);
		wait_idle();
		chk(irq, 16'h0001);
		chk(blk, 16'h0001);
		u_fspc_cpu_model.op(8'h01, 1, 1'b0);
		look(2);
		chk(blk, 16'h0000);
		$display("t_irq done");
	endtask : t_irq
	task close_out;
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : close_out
	initial begin
		repeat (3000) @(posedge clk);
		num_errors++;
		close_out();
	end
	initial begin
		reset = 1'b1;
		{gie, ee, bsz, z, dlo, dhi, ridx} = '0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		look(1);
		t_boot();
		t_fill();
		t_refuse();
		t_erase();
		t_lock();
		t_irq();
		close_out();
	end
endmodule : tb_fspc_ctrl
bind fspc_ctrl fspc_ctrl_checker #(.PROG_CYCLES(PROG_CYCLES)) u_fspc_ctrl_checker (.clk, .reset, .store_exec, .load_exec,
	.global_int_enable, .load_special_valid, .cpu_stall, .rww_read_blocked, .ready_irq,
	.flash_erase_start, .flash_write_start, .flash_busy, .flash_page);
